// ===== design/rfcal_regs.svh
`ifndef RFCAL_REGS_SVH
`define RFCAL_REGS_SVH

// Widths
`define RFCAL_ADDR_W        8
`define RFCAL_DATA_W        16
`define RFCAL_CAP_W         8
`define RFCAL_RC_W          8
`define RFCAL_NUM_SYNTH     2
`define RFCAL_NUM_STAGE     6

// Register byte offsets
`define RFCAL_OFS_CMP_CTRL  8'h00
`define RFCAL_OFS_CAP0      8'h04
`define RFCAL_OFS_CAP1      8'h08
`define RFCAL_OFS_CMP_STAT  8'h0C
`define RFCAL_OFS_STAGE0    8'h10
`define RFCAL_OFS_STAGE_END 8'h28
`define RFCAL_OFS_STAGE_TYP 8'h28

// Comparator control fields, two bits per synthesiser
`define RFCAL_CTRL_POWER_BIT 0
`define RFCAL_CTRL_THRSEL_BIT 1
`define RFCAL_CTRL_STRIDE    2

// Reset values
`define RFCAL_RST_CMP_CTRL  4'h0
`define RFCAL_RST_CAP       8'h80
`define RFCAL_RST_STAGE     16'h8080

// Stages 0..2 are trans-impedance, 3..5 voltage gain
`define RFCAL_STAGE_TIA_MASK 6'h07

`endif

// ===== design/rfcal_pkg.sv
`include "rfcal_regs.svh"

package rfcal_pkg;

    typedef struct packed {
        logic high;
        logic low;
    } rfcal_cmp_state_t;

    typedef struct packed {
        logic [`RFCAL_RC_W-1:0] r_code;
        logic [`RFCAL_RC_W-1:0] c_code;
    } rfcal_stage_cfg_t;

    typedef logic [`RFCAL_CAP_W-1:0] rfcal_cap_code_t;

endpackage

// ===== design/rfcal_cmp_sync.sv
`timescale 1ns/1ps
`include "rfcal_regs.svh"

module rfcal_cmp_sync (
    input  logic                       i_clk,
    input  logic                       i_reset_n,
    input  logic                       i_power,
    input  logic                       i_high,
    input  logic                       i_low,
    output rfcal_pkg::rfcal_cmp_state_t o_state
);

    rfcal_pkg::rfcal_cmp_state_t meta_q;
    rfcal_pkg::rfcal_cmp_state_t meta_d;
    rfcal_pkg::rfcal_cmp_state_t sync_q;
    rfcal_pkg::rfcal_cmp_state_t sync_d;
    rfcal_pkg::rfcal_cmp_state_t state_q;
    rfcal_pkg::rfcal_cmp_state_t state_d;

    always_comb begin
        meta_d.high = i_high;
        meta_d.low  = i_low;
        sync_d      = meta_q;
        // Unpowered comparators report 00
        state_d     = i_power ? sync_q : '0;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_q  <= '0;
            sync_q  <= '0;
            state_q <= '0;
        end else begin
            meta_q  <= meta_d;
            sync_q  <= sync_d;
            state_q <= state_d;
        end
    end

    assign o_state = state_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_cmp_power_gate: assert property (!$past(i_power) |-> o_state == '0)
        else $error("comparator state shown while unpowered");

    a_cmp_latency: assert property ($past(i_power) && $past(i_reset_n, 3)
        |-> o_state == $past({i_high, i_low}, 3))
        else $error("comparator state not three cycles behind pins");

endmodule

// ===== design/rfcal_top.sv
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "rfcal_regs.svh"

// Function
// - Two tuning comparators, selectable low threshold
// - Powered comparator states readable as status
// - Each stage has resistor and capacitor codes
// - Codes scale all stage parts equally
// - Stages classed trans-impedance or voltage gain
module rfcal_top (
    input  logic                                i_clk,
    input  logic                                i_reset_n,
    input  logic [`RFCAL_ADDR_W-1:0]            i_addr,
    input  logic [`RFCAL_DATA_W-1:0]            i_wdata,
    input  logic                                i_wr,
    input  logic                                i_rd,
    output logic [`RFCAL_DATA_W-1:0]            o_rdata,
    input  logic [`RFCAL_NUM_SYNTH-1:0]         i_cmp_high,
    input  logic [`RFCAL_NUM_SYNTH-1:0]         i_cmp_low,
    output logic [`RFCAL_NUM_SYNTH-1:0]         o_cmp_power,
    output logic [`RFCAL_NUM_SYNTH-1:0]         o_low_thr_sel,
    output rfcal_pkg::rfcal_cap_code_t [`RFCAL_NUM_SYNTH-1:0] o_vco_cap,
    output rfcal_pkg::rfcal_stage_cfg_t [`RFCAL_NUM_STAGE-1:0] o_stage_cfg,
    output logic [`RFCAL_NUM_STAGE-1:0]         o_stage_is_tia
);

    localparam logic [`RFCAL_NUM_STAGE-1:0] STAGE_TIA = `RFCAL_STAGE_TIA_MASK;

    function automatic logic is_stage(input logic [`RFCAL_ADDR_W-1:0] a);
        is_stage = (a >= `RFCAL_OFS_STAGE0) && (a < `RFCAL_OFS_STAGE_END) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] stage_index(input logic [`RFCAL_ADDR_W-1:0] a);
        logic [`RFCAL_ADDR_W-1:0] rel;
        rel = a - `RFCAL_OFS_STAGE0;
        stage_index = rel[4:2];
    endfunction

    logic [2*`RFCAL_NUM_SYNTH-1:0]                   ctrl_q;
    logic [2*`RFCAL_NUM_SYNTH-1:0]                   ctrl_d;
    rfcal_pkg::rfcal_cap_code_t [`RFCAL_NUM_SYNTH-1:0]  cap_q;
    rfcal_pkg::rfcal_cap_code_t [`RFCAL_NUM_SYNTH-1:0]  cap_d;
    rfcal_pkg::rfcal_stage_cfg_t [`RFCAL_NUM_STAGE-1:0] stage_q;
    rfcal_pkg::rfcal_stage_cfg_t [`RFCAL_NUM_STAGE-1:0] stage_d;
    logic [`RFCAL_DATA_W-1:0]                        rdata_q;
    logic [`RFCAL_DATA_W-1:0]                        rdata_d;
    rfcal_pkg::rfcal_cmp_state_t [`RFCAL_NUM_SYNTH-1:0] cmp_state;
    logic [2*`RFCAL_NUM_SYNTH-1:0]                   cmp_status;

    genvar g;
    generate
        for (g = 0; g < `RFCAL_NUM_SYNTH; g++) begin : g_synth
            assign o_cmp_power[g] =
                ctrl_q[g*`RFCAL_CTRL_STRIDE + `RFCAL_CTRL_POWER_BIT];
            // Low threshold: 0 selects the higher setting, 1 the lower
            assign o_low_thr_sel[g] =
                ctrl_q[g*`RFCAL_CTRL_STRIDE + `RFCAL_CTRL_THRSEL_BIT];
            rfcal_cmp_sync u_cmp (
                .i_clk     (i_clk),
                .i_reset_n (i_reset_n),
                .i_power   (o_cmp_power[g]),
                .i_high    (i_cmp_high[g]),
                .i_low     (i_cmp_low[g]),
                .o_state   (cmp_state[g])
            );
            // Pair per synthesiser: {high, low}
            assign cmp_status[2*g+1 -: 2] = cmp_state[g];
        end
    endgenerate

    // Register writes
    always_comb begin
        ctrl_d  = ctrl_q;
        cap_d   = cap_q;
        stage_d = stage_q;
        if (i_wr) begin
            if (i_addr == `RFCAL_OFS_CMP_CTRL) begin
                ctrl_d = i_wdata[2*`RFCAL_NUM_SYNTH-1:0];
            end
            if (i_addr == `RFCAL_OFS_CAP0) begin
                cap_d[0] = i_wdata[`RFCAL_CAP_W-1:0];
            end
            if (i_addr == `RFCAL_OFS_CAP1) begin
                cap_d[1] = i_wdata[`RFCAL_CAP_W-1:0];
            end
            if (is_stage(i_addr)) begin
                // One resistor and one capacitor code per stage
                stage_d[stage_index(i_addr)] = i_wdata;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            if (i_addr == `RFCAL_OFS_CMP_CTRL) begin
                rdata_d[2*`RFCAL_NUM_SYNTH-1:0] = ctrl_q;
            end else if (i_addr == `RFCAL_OFS_CAP0) begin
                rdata_d[`RFCAL_CAP_W-1:0] = cap_q[0];
            end else if (i_addr == `RFCAL_OFS_CAP1) begin
                rdata_d[`RFCAL_CAP_W-1:0] = cap_q[1];
            end else if (i_addr == `RFCAL_OFS_CMP_STAT) begin
                rdata_d[2*`RFCAL_NUM_SYNTH-1:0] = cmp_status;
            end else if (is_stage(i_addr)) begin
                rdata_d = stage_q[stage_index(i_addr)];
            end else if (i_addr == `RFCAL_OFS_STAGE_TYP) begin
                rdata_d[`RFCAL_NUM_STAGE-1:0] = STAGE_TIA;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_q  <= `RFCAL_RST_CMP_CTRL;
            cap_q   <= {`RFCAL_NUM_SYNTH{`RFCAL_RST_CAP}};
            stage_q <= {`RFCAL_NUM_STAGE{`RFCAL_RST_STAGE}};
            rdata_q <= '0;
        end else begin
            ctrl_q  <= ctrl_d;
            cap_q   <= cap_d;
            stage_q <= stage_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata        = rdata_q;
    assign o_vco_cap      = cap_q;
    assign o_stage_cfg    = stage_q;
    assign o_stage_is_tia = STAGE_TIA;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_status_read;
        i_rd && (i_addr == `RFCAL_OFS_CMP_STAT);
    endsequence

    sequence s_stage_write;
        i_wr && is_stage(i_addr);
    endsequence

    a_thr_sel_write: assert property (i_wr && i_addr == `RFCAL_OFS_CMP_CTRL
        |=> o_low_thr_sel[0] == $past(i_wdata[`RFCAL_CTRL_THRSEL_BIT])
            && o_cmp_power[0] == $past(i_wdata[`RFCAL_CTRL_POWER_BIT]))
        else $error("threshold select or power not taken from write");

    a_status_read: assert property (s_status_read
        |=> o_rdata[2*`RFCAL_NUM_SYNTH-1:0] == $past(cmp_status)
            && o_rdata[`RFCAL_DATA_W-1:2*`RFCAL_NUM_SYNTH] == '0)
        else $error("comparator status read wrong");

    a_status_unpowered: assert property (s_status_read and (!o_cmp_power[0]
        && !$past(o_cmp_power[0])) |=> o_rdata[1:0] == 2'h0)
        else $error("unpowered comparator pair not read as 00");

    a_stage_write: assert property (s_stage_write
        |=> o_stage_cfg[stage_index($past(i_addr))] == $past(i_wdata))
        else $error("stage codes not updated by write");

    a_stage_hold: assert property (!i_wr |=> $stable(o_stage_cfg))
        else $error("stage codes changed without a write");

    a_stage_type: assert property (o_stage_is_tia == 6'h07
        and (i_rd && i_addr == `RFCAL_OFS_STAGE_TYP |=> o_rdata == 16'h0007))
        else $error("stage type classification wrong");

    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
        else $error("read data present outside the read answer cycle");

endmodule

// ===== test/rfcal_vco_model.sv
`timescale 1ns/1ps
`include "rfcal_regs.svh"
// Tuning voltage falls as the code rises; unpowered comparators float high
module rfcal_vco_model #(
    parameter int LO_CODE = 8'h30,
    parameter int HI_CODE = 8'h90
) (
    input  rfcal_pkg::rfcal_cap_code_t [`RFCAL_NUM_SYNTH-1:0] i_cap,
    input  logic [`RFCAL_NUM_SYNTH-1:0]                      i_power,
    output logic [`RFCAL_NUM_SYNTH-1:0]                      o_high,
    output logic [`RFCAL_NUM_SYNTH-1:0]                      o_low
);
    always_comb begin
        for (int s = 0; s < `RFCAL_NUM_SYNTH; s++) begin
            o_high[s] = !i_power[s] || (i_cap[s] >= LO_CODE + 8 * s);
            o_low[s]  = !i_power[s] || (i_cap[s] >= HI_CODE + 8 * s);
        end
    end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "rfcal_regs.svh"
module testbench;
    localparam int LO = 8'h30;
    localparam int HI = 8'h90;
    logic                              i_clk, i_reset_n, i_wr, i_rd;
    logic [7:0]                        i_addr;
    logic [15:0]                       i_wdata, o_rdata, d;
    logic [1:0]                        cmp_h, cmp_l, o_cmp_power, o_low_thr_sel;
    rfcal_pkg::rfcal_cap_code_t [1:0]  o_vco_cap;
    rfcal_pkg::rfcal_stage_cfg_t [5:0] o_stage_cfg;
    logic [5:0]                        o_stage_is_tia;
    int                                n_mismatch, samples_checked, cycles, seed, lo, hi, prev;
    int                                m[int];

    rfcal_top i_rfcal_top (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_high(cmp_h),
        .i_cmp_low(cmp_l), .o_cmp_power(o_cmp_power), .o_low_thr_sel(o_low_thr_sel),
        .o_vco_cap(o_vco_cap), .o_stage_cfg(o_stage_cfg), .o_stage_is_tia(o_stage_is_tia));
    rfcal_vco_model #(.LO_CODE(LO), .HI_CODE(HI)) i_rfcal_vco_model (.i_cap(o_vco_cap),
        .i_power(o_cmp_power), .o_high(cmp_h), .o_low(cmp_l));

    function automatic int mrd(int a);
        int r;
        r = m.exists(a) ? m[a] : 0;
        if (a == 8'h28) r = 16'h0007;
        if (a == 8'h0C)
            for (int s = 0; s < 2; s++)
                if (m[0][2*s]) r |= (2 * (m[4+4*s] >= LO + 8*s) + (m[4+4*s] >= HI + 8*s)) << 2*s;
        return r;
    endfunction
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(int a, int v);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a[7:0];
        i_wdata <= v[15:0];
        @(posedge i_clk);
        i_wr <= 1'b0;
        if (m.exists(a)) m[a] = v & (a == 0 ? 16'h000F : a < 16 ? 16'h00FF : 16'hFFFF);
        #1;
    endtask
    task automatic rd(int a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a[7:0];
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 check(o_rdata, 16'(mrd(a)));
        d = o_rdata;
    endtask
    task automatic chk_out();
        for (int s = 0; s < 2; s++) begin
            check(16'(o_cmp_power[s]), 16'(m[0][2*s]));
            check(16'(o_low_thr_sel[s]), 16'(m[0][2*s+1]));
            check(16'(o_vco_cap[s]), 16'(m[4+4*s]));
        end
        for (int k = 0; k < 6; k++) check(o_stage_cfg[k], 16'(m[16+4*k]));
        check(16'(o_stage_is_tia), 16'h0007);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        {i_reset_n, i_wr, i_rd, i_addr, i_wdata} = '0;
        seed = 32'h8a29;
        m[0] = 0;
        m[4] = 8'h80;
        m[8] = 8'h80;
        for (int k = 0; k < 6; k++) m[16+4*k] = 16'h8080;
        repeat (4) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1 chk_out();
        for (int a = 0; a < 8'h34; a += 4) rd(a);
        rd(8'h03);
        // Random writes, including read-only and unmapped offsets
        for (int i = 0; i < 40; i++) begin
            lo = 4 * ($unsigned($random(seed)) % 12);
            wr(lo, $random(seed));
            chk_out();
            if (lo != 12) rd(lo);
        end
        // Pass-band search per stage: capacitor steps, then a resistor change
        for (int k = 0; k < 6; k++) begin
            for (int c = 8'h40; c < 8'h44; c++) wr(16 + 4*k, 16'h8000 | c);
            wr(16 + 4*k, 16'h9040);
            rd(16 + 4*k);
        end
        chk_out();
        wr(0, 0);
        repeat (4) @(posedge i_clk);
        rd(12);
        for (int s = 0; s < 2; s++) begin
            wr(0, 5 | ($random(seed) & 10));
            lo = -1;
            hi = -1;
            prev = 0;
            for (int c = 0; c < 256 && hi < 0; c++) begin
                wr(4 + 4*s, c);
                repeat (4) @(posedge i_clk);
                rd(12);
                d = (d >> 2*s) & 16'h0003;
                if (prev == 0 && d == 2) lo = c;
                if (prev == 2 && d == 3) hi = c;
                prev = d;
            end
            check(16'(lo), 16'(LO + 8*s));
            check(16'(hi), 16'(HI + 8*s));
            wr(4 + 4*s, (lo + hi) / 2);
            chk_out();
        end
        report_and_stop();
    end
endmodule
